// ---- src/hcw_map.svh ----
// Constants for the CPU clock source and oscillator watchdog block
`ifndef HCW_MAP_SVH
`define HCW_MAP_SVH

// ****************************************
// Mode pin encodings
// ****************************************
`define HCW_MODE_X4      3'h7
`define HCW_MODE_X3      3'h6
`define HCW_MODE_X8      3'h5
`define HCW_MODE_X5      3'h4
`define HCW_MODE_DIRECT  3'h3
`define HCW_MODE_X10     3'h2
`define HCW_MODE_PRESC   3'h1
`define HCW_MODE_X16     3'h0

// ****************************************
// Watchdog and timing
// ****************************************
`define HCW_SYSCFG_OWD_DIS_BIT 4
`define HCW_OWD_LIMIT          16
`define HCW_MCLK_PERIOD_NS     10
`define HCW_PLL_FREE_PERIOD_NS 40
`define HCW_PLL_FREE_DIV       (`HCW_PLL_FREE_PERIOD_NS / `HCW_MCLK_PERIOD_NS)
`define HCW_CAPTURE_DELAY      2'h2

`endif

// ---- src/hcw_pkg.sv ----
// Types for the CPU clock source and oscillator watchdog block
package hcw_pkg;

   typedef enum logic [3:0] {
      HCW_SRC_WAIT = 4'b0001,
      HCW_SRC_EXT  = 4'b0010,
      HCW_SRC_PLL  = 4'b0100,
      HCW_SRC_FAIL = 4'b1000
   } hcw_src_type;

   typedef struct packed {
      logic pll_on;
      logic amp_bypass;
      logic on_pll_free;
      logic owd_irq;
   } hcw_status_type;

endpackage

// ---- src/hcw_owd_counter.sv ----
// Oscillator watchdog counter: free-running ticks cleared by input transitions
`timescale 1ns/1ps
module hcw_owd_counter #(
   parameter int W     = 5,
   parameter int LIMIT = 16
) (
   input  wire logic i_mclk,      // System clock
   input  wire logic i_rst_b,     // Async reset, active low
   input  wire logic i_enable,    // Supervision active
   input  wire logic i_tick,      // Free-running PLL tick
   input  wire logic i_clear,     // External clock transition
   output logic      o_overflow   // Failure seen, sticky while enabled
);
   logic [W-1:0] count;

   // Clear wins over a tick in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count <= '0;
      end else if (!i_enable || i_clear) begin
         count <= '0;
      end else if (i_tick && !o_overflow) begin
         count <= count + W'(1);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_overflow <= 1'b0;
      end else if (!i_enable) begin
         o_overflow <= 1'b0;
      end else if (i_tick && !i_clear && count == W'(LIMIT - 1)) begin
         o_overflow <= 1'b1;
      end
   end

   property p_ovf_count;
      @(posedge i_mclk) disable iff (!i_rst_b)
      $rose(o_overflow) |-> $past(count) == W'(LIMIT - 1) && $past(i_tick);
   endproperty
   a_ovf_count: assert property (p_ovf_count) else $error("Overflow before limit");

   property p_clear;
      @(posedge i_mclk) disable iff (!i_rst_b)
      i_clear |=> count == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("Transition did not clear count");

endmodule

// ---- src/hcw_clock_ctrl.sv ----
// CPU clock source selection, clock generation and oscillator watchdog
`timescale 1ns/1ps
`include "hcw_map.svh"

// Notes on behaviour
// - Clock mechanism chosen from three mode pins
// - Encodings give x4,x3,x8,x5,x1,x10,/2,x16
// - Mode 001 divides oscillator clock by two
// - Prescaler phases each last one input period
// - Mode 011 bypasses amplifier, PLL off only with watchdog disabled
// - Direct drive follows input frequency and duty
// - Both CPU clock edges usable as events
// - Watchdog on by default, disable input bit
// - Supervision only in direct or prescaler mode
// - Free-run ticks count, input transitions clear
// - Overflow after sixteen ticks without transition
// - Overflow switches to PLL, raises request
// - Failover sticks until hardware or bidirectional reset
// - Watchdog disabled in direct or prescaler mode: external clock, PLL off
// - PLL modes multiply input by chosen factor
module hcw_clock_ctrl
   import hcw_pkg::*;
#(
   parameter int PER_W = 16
) (
   input  wire logic       i_mclk,                 // 100 MHz system clock
   input  wire logic       i_rst_b,                // Async hardware reset, active low
   input  wire logic       i_sw_reset,             // Bidirectional sw/wdt reset pulse
   input  wire logic       i_crystal_input_pin,    // External clock pin, async
   input  wire logic [2:0] i_clock_mode_pins,      // Mode straps, async
   input  wire logic       i_osc_watchdog_disable, // System config bit 4
   output logic            o_cpu_clk,              // Generated CPU clock
   output logic            o_cpu_edge,             // Pulse on each CPU clock edge
   output logic [2:0]      o_clock_mode,           // Latched mode
   output hcw_status_type  o_status                // Source and request status
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic       xtal_m, xtal_s, xtal_d;
   logic [2:0] mode_m, mode_s;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         xtal_m <= 1'b0;
         xtal_s <= 1'b0;
         xtal_d <= 1'b0;
         mode_m <= 3'h0;
         mode_s <= 3'h0;
      end else begin
         xtal_m <= i_crystal_input_pin;
         xtal_s <= xtal_m;
         xtal_d <= xtal_s;
         mode_m <= i_clock_mode_pins;
         mode_s <= mode_m;
      end
   end

   logic xtal_rise, xtal_edge;
   assign xtal_rise = xtal_s & ~xtal_d;
   assign xtal_edge = xtal_s ^ xtal_d;

   // ****************************************
   // Mode capture and source state
   // ****************************************
   hcw_src_type state;
   logic [2:0]  mode;
   logic [1:0]  cap_cnt;
   logic        owd_ovf, ext_mode;

   // Straps are read only after the synchroniser has filled
   assign ext_mode = (mode_s == `HCW_MODE_DIRECT) || (mode_s == `HCW_MODE_PRESC);

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state   <= HCW_SRC_WAIT;
         mode    <= `HCW_MODE_X4;
         cap_cnt <= 2'h0;
      end else if (i_sw_reset) begin
         state   <= HCW_SRC_WAIT;
         cap_cnt <= 2'h0;
      end else begin
         unique case (state)
            HCW_SRC_WAIT: begin
               if (cap_cnt == `HCW_CAPTURE_DELAY) begin
                  mode  <= mode_s;
                  state <= ext_mode ? HCW_SRC_EXT : HCW_SRC_PLL;
               end else begin
                  cap_cnt <= cap_cnt + 2'h1;
               end
            end
            HCW_SRC_EXT: if (owd_ovf) begin
               state <= HCW_SRC_FAIL;
            end
            HCW_SRC_PLL: state <= HCW_SRC_PLL;
            HCW_SRC_FAIL: state <= HCW_SRC_FAIL;
            default: state <= HCW_SRC_WAIT;
         endcase
      end
   end

   // ****************************************
   // Free-running PLL tick and watchdog
   // ****************************************
   localparam int FREE_DIV = (`HCW_PLL_FREE_DIV < 1) ? 1 : `HCW_PLL_FREE_DIV;
   logic [7:0] free_cnt;
   logic       free_tick, owd_enable;

   // Watchdog only supervises non-multiplied modes
   assign owd_enable = (state == HCW_SRC_EXT) && !i_osc_watchdog_disable;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         free_cnt  <= 8'h00;
         free_tick <= 1'b0;
      end else if (owd_enable || state == HCW_SRC_FAIL) begin
         free_tick <= (free_cnt == 8'(FREE_DIV - 1));
         free_cnt  <= (free_cnt == 8'(FREE_DIV - 1)) ? 8'h00 : free_cnt + 8'h01;
      end else begin
         free_tick <= 1'b0;
         free_cnt  <= 8'h00;
      end
   end

   hcw_owd_counter #(
      .W     (5),
      .LIMIT (`HCW_OWD_LIMIT)
   ) u_owd (
      .i_mclk     (i_mclk),
      .i_rst_b    (i_rst_b),
      .i_enable   (owd_enable),
      .i_tick     (free_tick),
      .i_clear    (xtal_edge),
      .o_overflow (owd_ovf)
   );

   // ****************************************
   // Input period and PLL half period
   // ****************************************
   logic [PER_W-1:0] per_cnt, period, tcl_cnt, tcl_len;

   // Half period of the multiplied clock is period / (2 * factor)
   function automatic logic [PER_W-1:0] half_of(input logic [PER_W-1:0] p,
                                               input logic [2:0] m);
      logic [PER_W-1:0] h;
      h = '0;
      unique case (m)
         `HCW_MODE_X4:  h = p / PER_W'(8);
         `HCW_MODE_X3:  h = p / PER_W'(6);
         `HCW_MODE_X8:  h = p / PER_W'(16);
         `HCW_MODE_X5:  h = p / PER_W'(10);
         `HCW_MODE_X10: h = p / PER_W'(20);
         `HCW_MODE_X16: h = p / PER_W'(32);
         default:       h = PER_W'(1);
      endcase
      return (h == '0) ? PER_W'(1) : h;
   endfunction

   assign tcl_len = half_of(period, mode);

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         per_cnt <= '0;
         period  <= PER_W'(1);
      end else if (xtal_rise) begin
         period  <= per_cnt + PER_W'(1);
         per_cnt <= '0;
      end else if (per_cnt != '1) begin
         per_cnt <= per_cnt + PER_W'(1);
      end
   end

   // Reload only at zero while in PLL state, so a new period changes the rate smoothly
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tcl_cnt <= '0;
      end else if (state != HCW_SRC_PLL || tcl_cnt == '0) begin
         tcl_cnt <= tcl_len - PER_W'(1);
      end else begin
         tcl_cnt <= tcl_cnt - PER_W'(1);
      end
   end

   // ****************************************
   // CPU clock generation
   // ****************************************
   logic next_cpu_clk;

   always_comb begin
      next_cpu_clk = o_cpu_clk;
      unique case (state)
         HCW_SRC_WAIT: next_cpu_clk = 1'b0;
         HCW_SRC_EXT: if (mode == `HCW_MODE_DIRECT) begin
            next_cpu_clk = xtal_s;
         end else if (xtal_rise) begin
            next_cpu_clk = ~o_cpu_clk;
         end
         HCW_SRC_PLL: if (tcl_cnt == '0) begin
            next_cpu_clk = ~o_cpu_clk;
         end
         HCW_SRC_FAIL: if (free_tick) begin
            next_cpu_clk = ~o_cpu_clk;
         end
         default: next_cpu_clk = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cpu_clk  <= 1'b0;
         o_cpu_edge <= 1'b0;
      end else begin
         o_cpu_clk  <= next_cpu_clk;
         o_cpu_edge <= next_cpu_clk != o_cpu_clk;
      end
   end

   // ****************************************
   // Status outputs
   // ****************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_status     <= '0;
         o_clock_mode <= `HCW_MODE_X4;
      end else begin
         o_clock_mode         <= mode;
         o_status.pll_on      <= (state == HCW_SRC_PLL) || (state == HCW_SRC_FAIL)
                                 || owd_enable;
         o_status.amp_bypass  <= (state == HCW_SRC_EXT) && (mode == `HCW_MODE_DIRECT);
         o_status.on_pll_free <= state == HCW_SRC_FAIL;
         if (state == HCW_SRC_WAIT) begin
            o_status.owd_irq <= 1'b0;
         end else if (state == HCW_SRC_EXT && owd_ovf) begin
            o_status.owd_irq <= 1'b1;
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_mode_hold;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (state != HCW_SRC_WAIT && !i_sw_reset) |=> $stable(mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("Mode changed after capture");
   property p_presc_toggle;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (state == HCW_SRC_EXT && mode == `HCW_MODE_PRESC && xtal_rise)
      |=> o_cpu_clk != $past(o_cpu_clk);
   endproperty
   a_presc_toggle: assert property (p_presc_toggle) else $error("Prescaler missed edge");
   sequence s_direct_run;
      state == HCW_SRC_EXT && mode == `HCW_MODE_DIRECT ##1 state == HCW_SRC_EXT;
   endsequence
   property p_direct_follow;
      @(posedge i_mclk) disable iff (!i_rst_b)
      s_direct_run |-> o_cpu_clk == $past(xtal_s);
   endproperty
   a_direct_follow: assert property (p_direct_follow) else $error("Direct clock not following");
   sequence s_overflow;
      state == HCW_SRC_EXT && owd_ovf && !i_sw_reset;
   endsequence
   property p_fail_switch;
      @(posedge i_mclk) disable iff (!i_rst_b)
      s_overflow |=> state == HCW_SRC_FAIL ##1 o_status.on_pll_free && o_status.owd_irq;
   endproperty
   a_fail_switch: assert property (p_fail_switch) else $error("No failover on overflow");
   property p_fail_sticky;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (state == HCW_SRC_FAIL && !i_sw_reset) |=> state == HCW_SRC_FAIL;
   endproperty
   a_fail_sticky: assert property (p_fail_sticky) else $error("Failover left without reset");
   property p_owd_only_ext;
      @(posedge i_mclk) disable iff (!i_rst_b)
      owd_ovf |-> mode == `HCW_MODE_DIRECT || mode == `HCW_MODE_PRESC;
   endproperty
   a_owd_only_ext: assert property (p_owd_only_ext) else $error("Watchdog in PLL mode");
   property p_pll_off;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (state == HCW_SRC_EXT && i_osc_watchdog_disable) |=> !o_status.pll_on && !free_tick;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("PLL on with watchdog disabled");
   property p_edge_pulse;
      @(posedge i_mclk) disable iff (!i_rst_b)
      ##1 o_cpu_edge == (o_cpu_clk != $past(o_cpu_clk));
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("Edge pulse mismatch");
   property p_pll_tcl;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (state == HCW_SRC_PLL && tcl_cnt == '0) |=> o_cpu_clk != $past(o_cpu_clk);
   endproperty
   a_pll_tcl: assert property (p_pll_tcl) else $error("PLL half period missed");
endmodule

// ---- bench/hcw_xtal_src.sv ----
// Behavioural external clock source driving the crystal input pin
`timescale 1ns/1ps
module hcw_xtal_src (
   input  wire logic   i_run,      // Oscillates while high, freezes when low
   input  wire integer i_high_ns,  // High phase length in ns
   input  wire integer i_low_ns,   // Low phase length in ns
   output logic        o_pin       // Crystal input pin level
);
   // Odd start offset keeps the source unrelated in phase to the system clock
   initial begin
      o_pin = 1'b0;
      #3.7;
      forever begin
         if (o_pin) begin
            #(i_high_ns);
         end else begin
            #(i_low_ns);
         end
         // A dead oscillator sticks at its last level
         if (i_run) begin
            o_pin = ~o_pin;
         end
      end
   end
endmodule

// ---- bench/tb_hcw_clock_ctrl.sv ----
// Self-checking testbench for the CPU clock source and oscillator watchdog
`timescale 1ns/1ps
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin err_count++; \
   $display("unexpected at %0t: got %h, expected %h", $time, act, exp); end end
module tb_hcw_clock_ctrl;
   import hcw_pkg::*;
   logic           mclk;
   logic           rst_b;
   logic           sw_reset;
   logic [2:0]     mode_pins;
   logic           owd_dis;
   logic           xrun;
   int             xhigh;
   int             xlow;
   logic           xpin;
   logic           cpu_clk;
   logic           cpu_edge;
   logic [2:0]     clock_mode;
   hcw_status_type status;
   int             err_count;
   int             num_checks;
   int             h[$];
   int             n;
   // Expected toggles in 960 cycles with a 480-cycle input period, by mode
   int             tog[8] = '{64, 2, 40, 4, 20, 32, 12, 16};

   hcw_xtal_src i_src (.i_run(xrun), .i_high_ns(xhigh), .i_low_ns(xlow), .o_pin(xpin));
   hcw_clock_ctrl i_dut (
      .i_mclk                 (mclk),
      .i_rst_b                (rst_b),
      .i_sw_reset             (sw_reset),
      .i_crystal_input_pin    (xpin),
      .i_clock_mode_pins      (mode_pins),
      .i_osc_watchdog_disable (owd_dis),
      .o_cpu_clk              (cpu_clk),
      .o_cpu_edge             (cpu_edge),
      .o_clock_mode           (clock_mode),
      .o_status               (status)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ****************************************
   // Reference model and helpers
   // ****************************************
   function automatic logic [3:0] exp_stat(input logic [2:0] m, input logic dis);
      logic ext;
      ext = (m == 3'h3) || (m == 3'h1);
      return {(!ext || !dis), (m == 3'h3), 1'b0, 1'b0};
   endfunction

   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [2:0] m);
      @(posedge mclk);
      rst_b     <= 1'b0;
      mode_pins <= m;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask

   // Collects cycle counts between CPU clock changes; first entry is partial
   task automatic halves(input int cnt);
      int   c;
      int   t;
      logic p;
      h = {};
      c = 0;
      t = 0;
      @(posedge mclk);
      #1 p = cpu_clk;
      while (h.size() < cnt && t < 5000) begin
         @(posedge mclk);
         #1;
         t++;
         c++;
         if (cpu_clk !== p) begin
            `CHK(cpu_edge, 1'b1)
            h.push_back(c);
            c = 0;
            p = cpu_clk;
         end else begin
            `CHK(cpu_edge, 1'b0)
         end
      end
      if (t >= 5000) begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic count_tog(input int cyc);
      logic p;
      n = 0;
      @(posedge mclk);
      #1 p = cpu_clk;
      repeat (cyc) begin
         @(posedge mclk);
         #1;
         if (cpu_clk !== p) n++;
         p = cpu_clk;
      end
   endtask

   function automatic logic near(input int a, input int e, input int tol);
      return (a >= e - tol) && (a <= e + tol);
   endfunction

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int w;
      rst_b = 1'b0;
      sw_reset = 1'b0;
      mode_pins = 3'h7;
      owd_dis = 1'b1;
      xrun = 1'b1;
      xhigh = 2400;
      xlow = 2400;
      err_count = 0;
      num_checks = 0;
      void'($urandom(32'hAB7E0B91));
      // Every encoding, ratio and latch with a slow input clock
      for (int m = 0; m < 8; m++) begin
         do_reset(m[2:0]);
         `CHK(clock_mode, m[2:0])
         `CHK(status, exp_stat(m[2:0], 1'b1))
         mode_pins <= 3'($urandom);
         repeat (1000) @(posedge mclk);
         count_tog(960);
         `CHK(near(n, tog[m], 1), 1'b1)
         `CHK(clock_mode, m[2:0])
      end
      // Direct drive, uneven duty, watchdog on
      owd_dis <= 1'b0;
      xhigh = 300;
      xlow = 200;
      do_reset(3'h3);
      `CHK(status, exp_stat(3'h3, 1'b0))
      halves(9);
      for (int i = 1; i < 9; i += 2) begin
         `CHK(near(h[i] + h[i + 1], 50, 1), 1'b1)
      end
      `CHK(status.on_pll_free, 1'b0)
      // Prescaler: each phase one input period
      xhigh = 250;
      xlow = 250;
      do_reset(3'h1);
      `CHK(status, exp_stat(3'h1, 1'b0))
      halves(6);
      for (int i = 1; i < 6; i++) begin
         `CHK(near(h[i], 50, 1), 1'b1)
      end
      `CHK(status.owd_irq, 1'b0)
      // Clock failure in direct drive
      xhigh = 50;
      xlow = 50;
      do_reset(3'h3);
      xrun = 1'b0;
      w = 0;
      while (status.on_pll_free !== 1'b1 && w < 200) begin
         @(posedge mclk);
         w++;
      end
      `CHK(near(w, 70, 12), 1'b1)
      if (w >= 200) begin
         err_count++;
         end_of_test();
      end
      `CHK(status.owd_irq, 1'b1)
      halves(5);
      `CHK(near(h[2] + h[3], 8, 0), 1'b1)
      xrun = 1'b1;
      repeat (200) @(posedge mclk);
      `CHK(status.on_pll_free, 1'b1)
      `CHK(status.owd_irq, 1'b1)
      sw_reset <= 1'b1;
      @(posedge mclk);
      sw_reset <= 1'b0;
      repeat (10) @(posedge mclk);
      `CHK(status, exp_stat(3'h3, 1'b0))
      // Disabled watchdog never fails over
      owd_dis <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK(status.pll_on, 1'b0)
      xrun = 1'b0;
      repeat (200) @(posedge mclk);
      `CHK(status.on_pll_free, 1'b0)
      // PLL mode is not supervised
      owd_dis <= 1'b0;
      xrun = 1'b1;
      do_reset(3'h7);
      xrun = 1'b0;
      repeat (200) @(posedge mclk);
      `CHK(status.owd_irq, 1'b0)
      `CHK(status.on_pll_free, 1'b0)
      `CHK(status.pll_on, 1'b1)
      end_of_test();
   end
endmodule
